// ==== bench/frame_master.sv ====
// Network master model: frame events and master byte accesses
`timescale 1ns/10ps
module frame_master
    import dc_time_pkg::*;
(
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic [7:0] master_rdata,
    output byte_acc_s master_acc,
    output write_kind_e master_kind,
    output frame_evt_s frame_evt
);
    // Enabled edges so far, the bench's time ruler
    int unsigned edges = 0;

    // Idle bus, no events
    initial begin
        master_acc = '0;
        master_kind = WK_OTHER;
        frame_evt = '0;
    end

    // Counts only enabled edges, as the local time does
    always @(posedge ref_clk) begin
        if (clk_en) begin
            edges <= edges + 1;
        end
    end

    // One byte access; idle data inverted so a stale byte shows
    task automatic acc(input logic rd, input logic [11:0] a,
            input logic [7:0] d, input write_kind_e k, output logic [7:0] q);
        @(posedge ref_clk);
        master_acc <= '{rd: rd, wr: !rd, addr: a, wdata: d};
        master_kind <= k;
        @(posedge ref_clk);
        master_acc <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: ~d};
        master_kind <= WK_OTHER;
        #1;
        q = master_rdata;
    endtask

    // Little-endian write of n bytes
    task automatic mwr(input logic [11:0] a, input int n,
            input logic [63:0] v, input write_kind_e k);
        logic [7:0] q;
        for (int i = 0; i < n; i++) begin
            acc(1'b0, a + 12'(i), v[8*i +: 8], k, q);
        end
    endtask

    // Little-endian read of n bytes
    task automatic mrd(input logic [11:0] a, input int n,
            output logic [63:0] v);
        logic [7:0] q;
        v = '0;
        for (int i = 0; i < n; i++) begin
            acc(1'b1, a + 12'(i), 8'h00, WK_OTHER, q);
            v[8*i +: 8] = q;
        end
    endtask

    // One-cycle frame event; returns the edge that took it
    task automatic pulse(input frame_evt_s ev, output int unsigned at);
        @(posedge ref_clk);
        frame_evt <= ev;
        @(posedge ref_clk);
        frame_evt <= '0;
        #1;
        at = edges;
    endtask
endmodule // frame_master

// ==== bench/tb.sv ====
// Bench for the receive-time and global-time block
`timescale 1ns/10ps
module tb
    import dc_time_pkg::*;
;
    // Offset and delay values, low offset byte zero on purpose
    localparam logic [63:0] OFS = 64'h0000_0001_0000_0100;
    localparam logic [63:0] DLY = 64'h0000_0000_0000_0250;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic port0_open = 1'b1;
    logic host_controls_time = 1'b0;
    logic [31:0] latch_input_zero_rise_time = 32'h0000_0000;
    byte_acc_s host_acc = '0;
    byte_acc_s master_acc;
    write_kind_e master_kind;
    frame_evt_s frame_evt;
    logic [7:0] master_rdata;
    logic [7:0] host_rdata;
    logic [31:0] loop_diff;
    logic loop_diff_valid;
    logic loop_diff_host;
    int err_total = 0;
    int comparisons = 0;

    // 250 MHz clock
    always #2 ref_clk = ~ref_clk;

    dc_receive_time i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .clk_en(clk_en), .master_acc(master_acc), .master_kind(master_kind),
        .master_rdata(master_rdata), .host_acc(host_acc),
        .host_rdata(host_rdata), .frame_evt(frame_evt),
        .port0_open(port0_open), .host_controls_time(host_controls_time),
        .latch_input_zero_rise_time(latch_input_zero_rise_time), .loop_diff(loop_diff),
        .loop_diff_valid(loop_diff_valid), .loop_diff_host(loop_diff_host));

    frame_master i_master (.ref_clk(ref_clk), .clk_en(clk_en),
        .master_rdata(master_rdata), .master_acc(master_acc),
        .master_kind(master_kind), .frame_evt(frame_evt));

    // Value compare
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Counts, verdict, end of run
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // One host byte access, bus idles after it
    task automatic hacc(input logic rd, input logic [11:0] a,
            input logic [7:0] d, output logic [7:0] q);
        @(posedge ref_clk);
        host_acc <= '{rd: rd, wr: !rd, addr: a, wdata: d};
        @(posedge ref_clk);
        host_acc <= '{rd: 1'b0, wr: 1'b0, addr: a, wdata: ~d};
        #1;
        q = host_rdata;
    endtask

    // Host read of n bytes; gap cycles after byte 0, its edge in at
    task automatic hrd(input logic [11:0] a, input int n, input int gap,
            output logic [63:0] v, output int unsigned at);
        logic [7:0] q;
        v = '0;
        for (int i = 0; i < n; i++) begin
            hacc(1'b1, a + 12'(i), 8'h00, q);
            v[8*i +: 8] = q;
            if (i == 0) begin
                at = i_master.edges;
                repeat (gap) @(posedge ref_clk);
            end
        end
    endtask

    // Bounded wait for a compare result
    task automatic wait_valid();
        int n;
        n = 0;
        while (loop_diff_valid !== 1'b1 && n < 4) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (loop_diff_valid !== 1'b1) begin
            err_total++;
            close_out();
        end
    endtask

    // Trigger frames of each write kind, port 0 open and closed
    task automatic trig_test();
        logic [63:0] s0, s1, su, t0, tu;
        int unsigned p0, p1, pu, e, q0;
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk);
            port0_open <= (k != 1);
            i_master.pulse(5'h10, p0);
            i_master.pulse(5'h08, p1);
            i_master.pulse(5'h04, pu);
            i_master.pulse(5'h02, e);
            i_master.mwr(ADDR_RCV_P0, 1, 64'h0000_0000_0000_005A,
                k == 2 ? WK_OTHER : write_kind_e'(k + 1));
            i_master.pulse(5'h01, e);
            // stamps read only after the frame
            i_master.mrd(ADDR_RCV_P0, 4, s0);
            hrd(ADDR_RCV_P1, 4, 0, s1, e);
            i_master.mrd(ADDR_RCV_PU, 8, su);
            if (k == 2) begin
                check(s0, t0);
                check(su, tu);
            end else begin
                check(s1 - s0, 64'(4 * (p1 - p0)));
                check(su, s0 + 64'(k * 4 * (pu - p0)));
            end
            if (k == 1) begin
                check(s0 - t0, 64'(4 * (p0 - q0)));
            end
            t0 = s0;
            tu = su;
            q0 = p0;
            hrd(ADDR_RCV_P0, 4, 0, s1, e);
            check(s1, s0);
        end
    endtask

    // Offset, clock freeze and host snapshot of the global time
    task automatic time_test();
        logic [63:0] t1, t2;
        int unsigned r1, r2;
        hrd(ADDR_SYS_TIME, 8, 0, t1, r1);
        i_master.mwr(ADDR_TIME_OFFSET, 8, OFS, WK_CONFIGURED);
        i_master.mwr(12'h0930, 2, 64'h0000_0000_0000_1000, WK_CONFIGURED);
        @(posedge ref_clk);
        clk_en <= 1'b0;
        repeat (10) @(posedge ref_clk);
        clk_en <= 1'b1;
        hrd(ADDR_SYS_TIME, 8, 300, t2, r2);
        check(t2, t1 + OFS + 64'(4 * (r2 - r1)));
        hrd(ADDR_TIME_OFFSET, 8, 0, t2, r2);
        check(t2, OFS);
        hrd(12'h0908, 4, 0, t2, r2);
        check(t2, 64'h0);
    endtask

    // SOF latch with delay, then a master compare
    task automatic sof_test();
        logic [63:0] l1, l2;
        int unsigned s1, s2, e;
        i_master.pulse(5'h02, s1);
        i_master.mrd(ADDR_SYS_TIME, 8, l1);
        i_master.pulse(5'h01, e);
        i_master.mwr(ADDR_TIME_DELAY, 4, DLY, WK_CONFIGURED);
        i_master.pulse(5'h02, s2);
        i_master.mrd(ADDR_SYS_TIME, 8, l2);
        i_master.mwr(ADDR_SYS_TIME, 4, 64'h0000_0000_1000_0000, WK_CONFIGURED);
        i_master.pulse(5'h01, e);
        check(l2 - l1, DLY + 64'(4 * (s2 - s1)));
        wait_valid();
        check({loop_diff_host, loop_diff}, {1'b0, l2[31:0] - 32'h1000_0000});
    endtask

    // Host ownership: master offset write refused, host compare
    task automatic host_test();
        logic [63:0] q;
        int unsigned r;
        @(posedge ref_clk);
        host_controls_time <= 1'b1;
        latch_input_zero_rise_time <= 32'h2000_0010;
        i_master.mwr(ADDR_TIME_OFFSET, 1, 64'h0000_0000_0000_00AA, WK_CONFIGURED);
        hrd(ADDR_TIME_OFFSET, 1, 0, q, r);
        check(q, {56'h0, OFS[7:0]});
        hacc(1'b0, ADDR_SYS_TIME, 8'h10, q[7:0]);
        hacc(1'b0, ADDR_SYS_TIME + 12'h001, 8'h00, q[7:0]);
        hacc(1'b0, ADDR_SYS_TIME + 12'h002, 8'h00, q[7:0]);
        hacc(1'b0, ADDR_SYS_TIME + 12'h003, 8'h00, q[7:0]);
        wait_valid();
        check({loop_diff_host, loop_diff}, {1'b1, 32'h2000_0000});
    endtask

    // Reset for 8 cycles, then the scenarios
    initial begin
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        trig_test();
        time_test();
        sof_test();
        host_test();
        close_out();
    end
endmodule // tb

// ==== rtl/dc_receive_time.sv ====
// Receive time stamps, global time copy and time loop compare inputs
// Function
// - Stamps are 32 or 64 bits wide
// - Trigger write latches preamble time per port
// - Port 0 read returns last trigger stamp
// - Port 1 stamp holds its preamble time
// - Master reads time latched at SOF
// - Host snapshots whole time on byte 0
// - Master write compared at frame end
// - Host write compared with latch zero
// - Processing unit stamp is 64 bits
// - Open port 0 gives same PU stamp
// - Global copy is local time plus offset
// - Loop registers written by master, host optional
// - Delay register added to master time
`timescale 1ns/10ps
module dc_receive_time
    import dc_time_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire byte_acc_s master_acc,
    input wire write_kind_e master_kind,
    output logic [7:0] master_rdata,
    input wire byte_acc_s host_acc,
    output logic [7:0] host_rdata,
    input wire frame_evt_s frame_evt,
    input wire logic port0_open,
    input wire logic host_controls_time,
    input wire logic [31:0] latch_input_zero_rise_time,
    output logic [31:0] loop_diff,
    output logic loop_diff_valid,
    output logic loop_diff_host
);

    logic [DC_WIDTH-1:0] local_time; // Free-running ns counter
    logic [63:0] time_offset; // Offset to the global time
    logic [31:0] time_delay; // Delay from the reference clock
    logic [63:0] sys_copy; // Local copy of the global time
    logic [63:0] sof_latch; // Copy taken at start of frame
    logic [63:0] host_snap; // Copy frozen for host byte reads
    logic [STAMP_WIDTH-1:0] pend_p0; // Stamps of the frame in flight
    logic [STAMP_WIDTH-1:0] pend_p1;
    logic [DC_WIDTH-1:0] pend_pu;
    logic [STAMP_WIDTH-1:0] p0_stamp; // Committed stamps
    logic [STAMP_WIDTH-1:0] p1_stamp;
    logic [DC_WIDTH-1:0] pu_stamp;
    logic frame_trig; // Frame carried a trigger write
    logic [31:0] m_wval; // Value written by the master
    logic [31:0] h_wval; // Value written by the host
    logic m_cmp_pend; // Master compare armed
    logic h_cmp_pend; // Host compare armed
    logic m_wr; // Qualified write strobes
    logic h_wr;
    logic trig_now; // Trigger write seen this cycle
    logic m_systime_wr; // Accepted writes to the low time word
    logic h_systime_wr;
    logic m_loop_wr; // Writer allowed on loop registers
    logic h_loop_wr;

    assign sys_copy = local_time + time_offset;

    assign m_wr = clk_en && master_acc.wr;
    assign h_wr = clk_en && host_acc.wr;
    assign trig_now = m_wr && master_acc.addr == ADDR_RCV_P0
        && (master_kind == WK_BROADCAST || master_kind == WK_CONFIGURED);
    // Only the owning side writes loop registers
    assign m_loop_wr = m_wr && !host_controls_time;
    assign h_loop_wr = h_wr && host_controls_time;
    assign m_systime_wr = m_loop_wr
        && master_acc.addr[11:2] == ADDR_SYS_TIME[11:2];
    assign h_systime_wr = h_loop_wr
        && host_acc.addr[11:2] == ADDR_SYS_TIME[11:2];

    // Picks one byte of the register space; st is the side's time view
    function automatic logic [7:0] pick(input logic [11:0] a,
                                        input logic [63:0] st);
        logic [63:0] w;
        w = RST_TIME;
        case (a[11:3])
            ADDR_RCV_P0[11:3]: w = {p1_stamp, p0_stamp};
            ADDR_SYS_TIME[11:3]: w = st;
            ADDR_RCV_PU[11:3]: w = pu_stamp;
            ADDR_TIME_OFFSET[11:3]: w = time_offset;
            ADDR_TIME_DELAY[11:3]: w = {RST_WORD, time_delay};
            default: w = RST_TIME; // Unmapped bytes read zero
        endcase
        return w[a[2:0]*8 +: 8];
    endfunction

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            local_time <= RST_TIME;
        end else if (clk_en) begin
            local_time <= local_time + TIME_STEP;
        end
    end

    // Preamble times of the frame in flight; kept apart from committed
    // stamps so a read in the same frame still sees the old values
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_p0 <= RST_WORD;
            pend_p1 <= RST_WORD;
            pend_pu <= RST_TIME;
        end else if (clk_en) begin
            // Port stamps take the low word
            if (frame_evt.port0_preamble) begin
                pend_p0 <= local_time[STAMP_WIDTH-1:0];
            end
            if (frame_evt.port1_preamble) begin
                pend_p1 <= local_time[STAMP_WIDTH-1:0];
            end
            // Open port 0 feeds the unit
            if (port0_open && frame_evt.port0_preamble) begin
                pend_pu <= local_time;
            end else if (!port0_open && frame_evt.pu_preamble) begin
                pend_pu <= local_time;
            end
        end
    end

    // Trigger flag of the current frame; a late write still counts
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            frame_trig <= 1'b0;
        end else if (clk_en) begin
            if (frame_evt.frame_end) begin
                frame_trig <= 1'b0;
            end else if (trig_now) begin
                frame_trig <= 1'b1;
            end
        end
    end

    // Commit at frame end, so new stamps show only from the next frame
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            p0_stamp <= RST_WORD;
            p1_stamp <= RST_WORD;
            pu_stamp <= RST_TIME;
        end else if (clk_en) begin
            if (frame_evt.frame_end && (frame_trig || trig_now)) begin
                p0_stamp <= pend_p0;
                p1_stamp <= pend_p1;
                pu_stamp <= pend_pu;
            end
        end
    end

    // Offset and delay bytes; the host owns them only when configured
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            time_offset <= RST_TIME;
            time_delay <= RST_WORD;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (m_loop_wr && master_acc.addr == ADDR_TIME_OFFSET + 12'(i))
                begin
                    time_offset[i*8 +: 8] <= master_acc.wdata;
                end else if (h_loop_wr
                             && host_acc.addr == ADDR_TIME_OFFSET + 12'(i))
                begin
                    time_offset[i*8 +: 8] <= host_acc.wdata;
                end
            end
            for (int i = 0; i < 4; i++) begin
                if (m_loop_wr && master_acc.addr == ADDR_TIME_DELAY + 12'(i))
                begin
                    time_delay[i*8 +: 8] <= master_acc.wdata;
                end else if (h_loop_wr
                             && host_acc.addr == ADDR_TIME_DELAY + 12'(i))
                begin
                    time_delay[i*8 +: 8] <= host_acc.wdata;
                end
            end
        end
    end

    // Time seen by the master, latched at the start-of-frame delimiter
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sof_latch <= RST_TIME;
        end else if (clk_en && frame_evt.sof) begin
            sof_latch <= sys_copy + {RST_WORD, time_delay};
        end
    end

    // Written compare values and their arming flags
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            m_wval <= RST_WORD;
            h_wval <= RST_WORD;
            m_cmp_pend <= 1'b0;
            h_cmp_pend <= 1'b0;
        end else if (clk_en) begin
            if (m_systime_wr) begin
                m_wval[master_acc.addr[1:0]*8 +: 8] <= master_acc.wdata;
            end
            // Arming by a byte 0 write wins over the frame-end clear
            if (m_systime_wr && master_acc.addr[2:0] == SYS_TIME_FIRST_BYTE)
            begin
                m_cmp_pend <= 1'b1;
            end else if (frame_evt.frame_end) begin
                m_cmp_pend <= 1'b0;
            end
            if (h_systime_wr) begin
                h_wval[host_acc.addr[1:0]*8 +: 8] <= host_acc.wdata;
            end
            // Host compare fires one cycle after the last byte
            h_cmp_pend <= h_systime_wr
                && host_acc.addr[2:0] == SYS_TIME_LAST_BYTE;
        end
    end

    // Difference to the time loop: SOF copy (master) or latch zero time (host) minus received time
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            loop_diff <= RST_WORD;
            loop_diff_valid <= 1'b0;
            loop_diff_host <= 1'b0;
        end else if (clk_en) begin
            loop_diff_valid <= 1'b0;
            if (frame_evt.frame_end && m_cmp_pend) begin
                loop_diff <= sof_latch[31:0] - m_wval;
                loop_diff_valid <= 1'b1;
                loop_diff_host <= 1'b0;
            end else if (h_cmp_pend) begin
                loop_diff <= latch_input_zero_rise_time - h_wval;
                loop_diff_valid <= 1'b1;
                loop_diff_host <= 1'b1;
            end
        end
    end

    // Read data, one cycle after the read strobe
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            master_rdata <= RST_BYTE;
            host_rdata <= RST_BYTE;
            host_snap <= RST_TIME;
        end else if (clk_en) begin
            if (master_acc.rd) begin
                master_rdata <= pick(master_acc.addr, sof_latch);
            end
            if (host_acc.rd && host_acc.addr == ADDR_SYS_TIME) begin
                host_snap <= sys_copy;
                host_rdata <= sys_copy[7:0];
            end else if (host_acc.rd) begin
                host_rdata <= pick(host_acc.addr, host_snap);
            end
        end
    end

    time_step_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en |=> local_time == $past(local_time) + TIME_STEP)
        else $error("local time did not advance by one step");

    commit_p0_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && frame_evt.frame_end && frame_trig
        |=> p0_stamp == $past(pend_p0) && pu_stamp == $past(pend_pu))
        else $error("trigger frame stamps not committed");

    stamp_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !frame_evt.frame_end |=> $stable(p0_stamp) && $stable(p1_stamp))
        else $error("receive stamp changed outside frame end");

    commit_p1_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && frame_evt.frame_end && trig_now
        |=> p1_stamp == $past(pend_p1))
        else $error("port 1 stamp not committed");

    pu_follow_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && port0_open && frame_evt.port0_preamble
        |=> pend_pu[31:0] == pend_p0)
        else $error("unit stamp differs from open port 0");

    sof_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && frame_evt.sof
        |=> sof_latch == $past(local_time) + $past(time_offset)
            + {32'h0000_0000, $past(time_delay)})
        else $error("start of frame copy lacks offset or delay");

    host_snap_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && host_acc.rd && host_acc.addr == ADDR_SYS_TIME
        |=> host_snap == $past(sys_copy) && host_rdata == host_snap[7:0])
        else $error("host time snapshot inconsistent");

    master_cmp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && frame_evt.frame_end && m_cmp_pend
        |=> loop_diff_valid && !loop_diff_host
            && loop_diff == $past(sof_latch[31:0]) - $past(m_wval))
        else $error("master compare result wrong");

    host_cmp_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        clk_en && h_systime_wr && host_acc.addr[2:0] == SYS_TIME_LAST_BYTE
        && !frame_evt.frame_end ##1 clk_en && !frame_evt.frame_end
        |=> loop_diff_valid && loop_diff_host)
        else $error("host compare not issued");

    owner_only_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        host_controls_time && !host_acc.wr |=> $stable(time_offset))
        else $error("master changed offset while host owns it");

endmodule // dc_receive_time

// ==== rtl/dc_time_pkg.sv ====
// Constants, types and register map of the receive-time and global-time block
package dc_time_pkg;

    // Stamp widths: ports keep 32 bits, the wide registers keep 64 bits
    localparam int DC_WIDTH = 64;
    localparam int STAMP_WIDTH = 32;

    // Clock period in ns; the local time counts in ns
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [63:0] TIME_STEP = 64'(CLK_PERIOD_NS);

    // Byte addresses of the registers
    localparam logic [11:0] ADDR_RCV_P0 = 12'h0900;
    localparam logic [11:0] ADDR_RCV_P1 = 12'h0904;
    localparam logic [11:0] ADDR_SYS_TIME = 12'h0910;
    localparam logic [11:0] ADDR_RCV_PU = 12'h0918;
    localparam logic [11:0] ADDR_TIME_OFFSET = 12'h0920;
    localparam logic [11:0] ADDR_TIME_DELAY = 12'h0928;

    // Byte lanes of the low global time word that arm a compare
    localparam logic [2:0] SYS_TIME_FIRST_BYTE = 3'h0;
    localparam logic [2:0] SYS_TIME_LAST_BYTE = 3'h3;

    // Reset values
    localparam logic [63:0] RST_TIME = 64'h0000_0000_0000_0000;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // Kind of a master write command
    typedef enum logic [1:0] {
        WK_OTHER = 2'b00,
        WK_BROADCAST = 2'b01,
        WK_CONFIGURED = 2'b10
    } write_kind_e;

    // One byte access to the register space
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } byte_acc_s;

    // Frame events from the frame handling logic, one-cycle pulses
    typedef struct packed {
        logic port0_preamble;
        logic port1_preamble;
        logic pu_preamble;
        logic sof;
        logic frame_end;
    } frame_evt_s;

endpackage
